// ### include/bwbr_pkg.sv
// Constants, encodings and helpers shared by the flash end and the host end
// of the burst-wrap / buffer-read link. No clock or reset assumptions.
package bwbr_pkg;

  localparam logic [7:0]  OP_WRAP_READ      = 8'h0c;
  localparam logic [7:0]  OP_BUFFER_READ    = 8'hd4;

  localparam logic [1:0]  LINE_SINGLE       = 2'h0;
  localparam logic [1:0]  LINE_QUAD         = 2'h1;
  localparam logic [1:0]  LINE_OCTAL        = 2'h2;

  // Wrap configuration field: mode select bit, then line length code
  localparam int          WRAP_MODE_BIT     = 2;
  localparam int          WRAP_LEN_LSB      = 0;
  localparam logic [2:0]  WRAP_CFG_RESET    = 3'h0;

  localparam int          ARRAY_ADDR_BITS   = 24;
  localparam int          BANK_LSB          = 21;
  localparam int          BANK_BITS         = 3;
  localparam int          BUF_BYTES         = 256;

  localparam logic [5:0]  BUFFER_DUMMY_CYC  = 6'h08;
  localparam logic [5:0]  WRAP_DUMMY_CYC    = 6'h0e;
  localparam logic [7:0]  UNDEFINED_BYTE    = 8'hff;
  localparam logic [3:0]  HOST_HALF_DIV     = 4'h8;

  function automatic logic [3:0] bitsPerCycle(input logic [1:0] mode);
    case (mode)
      LINE_SINGLE: return 4'h1;
      LINE_QUAD:   return 4'h4;
      default:     return 4'h8;
    endcase
  endfunction

  // Log2 of transfer units per byte
  function automatic logic [1:0] unitShift(input logic [1:0] mode);
    case (mode)
      LINE_SINGLE: return 2'h3;
      LINE_QUAD:   return 2'h1;
      default:     return 2'h0;
    endcase
  endfunction

  function automatic logic [5:0] opcodeCycles(input logic [1:0] mode);
    return 6'(8 >> (3 - unitShift(mode)));
  endfunction

  function automatic logic [5:0] addrCycles(input logic [1:0] mode);
    return 6'(32 >> (3 - unitShift(mode)));
  endfunction

  function automatic logic [6:0] lineLength(input logic [2:0] cfg);
    return 7'(8'h08 << cfg[WRAP_LEN_LSB +: 2]);
  endfunction

  // Lanes the flash end drives while returning data
  function automatic logic [7:0] dataLanes(input logic [1:0] mode);
    case (mode)
      LINE_SINGLE: return 8'h02;
      LINE_QUAD:   return 8'h0f;
      default:     return 8'hff;
    endcase
  endfunction

  // Lanes the host drives while sending command and address
  function automatic logic [7:0] cmdLanes(input logic [1:0] mode);
    case (mode)
      LINE_SINGLE: return 8'h01;
      LINE_QUAD:   return 8'h0f;
      default:     return 8'hff;
    endcase
  endfunction

  // One data unit of a byte, most significant part first
  function automatic logic [7:0] unitOut(input logic [7:0] data, input logic [2:0] part,
                                         input logic [1:0] mode);
    case (mode)
      LINE_SINGLE: return {6'h00, data[3'h7 - part], 1'b0};
      LINE_QUAD:   return {4'h0, part[0] ? data[3:0] : data[7:4]};
      default:     return data;
    endcase
  endfunction

  function automatic logic [7:0] cmdUnitIn(input logic [7:0] io, input logic [1:0] mode);
    case (mode)
      LINE_SINGLE: return {7'h00, io[0]};
      LINE_QUAD:   return {4'h0, io[3:0]};
      default:     return io;
    endcase
  endfunction

  function automatic logic [7:0] dataUnitIn(input logic [7:0] io, input logic [1:0] mode);
    case (mode)
      LINE_SINGLE: return {7'h00, io[1]};
      LINE_QUAD:   return {4'h0, io[3:0]};
      default:     return io;
    endcase
  endfunction

  // Stand-in array content, a fixed function of the byte address
  function automatic logic [7:0] patternByte(input logic [ARRAY_ADDR_BITS-1:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16];
  endfunction

endpackage

// ### include/bwbr_link_if.sv
// Serial flash link between the host end and the flash end.
// Resolves the shared data lanes from both ends' enables; idle lanes read high.
`timescale 1ns/1ps
`default_nettype none
interface bwbr_link_if;
  logic       csN;
  logic       sck;
  logic [7:0] hostIoOut;
  logic [7:0] hostIoOe;
  logic [7:0] devIoOut;
  logic [7:0] devIoOe;
  logic [7:0] ioLevel;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ioLevel[i] = devIoOe[i] ? devIoOut[i] : (hostIoOe[i] ? hostIoOut[i] : 1'b1);
    end
  end

  modport flash (input csN, input sck, input ioLevel, output devIoOut, output devIoOe);
  modport host (output csN, output sck, output hostIoOut, output hostIoOe, input ioLevel);
endinterface
`default_nettype wire

// ### core/bwbr_flash_end.sv
// Flash end: decodes wrap read and buffer read, returns data on the lanes.
// Link logic runs on sck; user-side settings arrive on clk and are resynchronised.
//
// What this block does
// - Wrap mode clear: loop one line forever
// - Line loop lasts while clock toggles
// - Mode set: finish first line, then next
// - Continuous mode streams successive lines
// - No extra cycles at line wrap
// - No extra cycles at line jump
// - Halted clock resumes next line, no command
// - Single rate halt levels show edge bytes
// - Double rate halt levels show edge bytes
// - Eight 16 Mbit banks, reads elsewhere allowed
// - Host avoids reading the busy bank
// - Buffer read: D4h, index in last byte
// - One dummy byte before buffer data
// - Host holds select through buffer read
// - Buffer index wraps to first byte
// - Select rising ends read, lanes released
// - Buffer read only in single-line mode
// - Config picks 8/16/32/64 byte lines
// - Wrap read 0Ch in quad/octal modes
`timescale 1ns/1ps
`default_nettype none
module bwbr_flash_end
  import bwbr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] wrapConfig,
  input  wire logic [1:0] lineMode,
  input  wire logic       dtrMode,
  input  wire logic       writeBusy,
  input  wire logic [2:0] busyBank,
  input  wire logic       bufWrEn,
  input  wire logic [7:0] bufWrIndex,
  input  wire logic [7:0] bufWrData,
  bwbr_link_if.flash      link
);

  typedef enum logic [2:0] {
    DEV_OPCODE,
    DEV_ADDRESS,
    DEV_DUMMY,
    DEV_DATA,
    DEV_IGNORE
  } bwbr_dev_state_type;

  localparam int         CFG_W     = 10;
  localparam logic [9:0] CFG_RESET = {1'b0, 3'h0, WRAP_CFG_RESET, LINE_SINGLE, 1'b0};

  logic [CFG_W-1:0]   cfgRaw;
  logic [CFG_W-1:0]   cfgS1;
  logic [CFG_W-1:0]   cfgS2;
  logic [CFG_W-1:0]   cfgS3;
  logic [CFG_W-1:0]   cfgHeld;
  logic [CFG_W-1:0]   cfgAgree;
  logic               wBusy;
  logic [2:0]         bBank;
  logic [2:0]         wCfg;
  logic [1:0]         mode;
  logic               dtr;
  logic               linkRst;
  logic [7:0]         bufMem [BUF_BYTES];
  bwbr_dev_state_type state;
  logic [5:0]         cnt;
  logic [5:0]         next_cnt;
  logic [31:0]        shiftIn;
  logic [31:0]        next_shift;
  logic [7:0]         opcode;
  logic [31:0]        addrReg;
  logic               isBuffer;
  logic [31:0]        negCnt;
  logic [7:0]         negData;
  logic [7:0]         posData;

  // Settings from the clk side, taken once stages two and three agree
  assign cfgRaw   = {writeBusy, busyBank, wrapConfig, lineMode, dtrMode};
  assign cfgAgree = ~(cfgS2 ^ cfgS3);

  always_ff @(posedge link.sck or posedge rst) begin
    if (rst) begin
      cfgS1   <= CFG_RESET;
      cfgS2   <= CFG_RESET;
      cfgS3   <= CFG_RESET;
      cfgHeld <= CFG_RESET;
    end else begin
      cfgS1   <= cfgRaw;
      cfgS2   <= cfgS1;
      cfgS3   <= cfgS2;
      cfgHeld <= (cfgS3 & cfgAgree) | (cfgHeld & ~cfgAgree);
    end
  end

  assign wBusy = cfgHeld[9];
  assign bBank = cfgHeld[8:6];
  assign wCfg  = cfgHeld[5:3];
  assign mode  = cfgHeld[2:1];
  assign dtr   = cfgHeld[0];

  // page buffer, loaded from the user side
  always_ff @(posedge clk) begin
    if (bufWrEn) begin
      bufMem[bufWrIndex] <= bufWrData;
    end
  end

  assign linkRst = rst | link.csN;

  always_comb begin
    next_cnt   = cnt + 6'h01;
    next_shift = (shiftIn << bitsPerCycle(mode)) | {24'h000000, cmdUnitIn(link.ioLevel, mode)};
  end

  assign opcode = next_shift[7:0];

  always_ff @(posedge link.sck or posedge linkRst) begin
    if (linkRst) begin
      state    <= DEV_OPCODE;
      cnt      <= 6'h00;
      shiftIn  <= 32'h00000000;
      addrReg  <= 32'h00000000;
      isBuffer <= 1'b0;
    end else begin
      case (state)
        DEV_OPCODE: begin
          shiftIn <= next_shift;
          cnt     <= next_cnt;
          if (next_cnt == opcodeCycles(mode)) begin
            cnt <= 6'h00;
            // wrap read only on four or eight lanes
            if (opcode == OP_WRAP_READ && mode != LINE_SINGLE) begin
              state    <= DEV_ADDRESS;
              isBuffer <= 1'b0;
            // buffer read only on one lane
            end else if (opcode == OP_BUFFER_READ && mode == LINE_SINGLE && !dtr) begin
              state    <= DEV_ADDRESS;
              isBuffer <= 1'b1;
            end else begin
              state <= DEV_IGNORE;
            end
          end
        end
        DEV_ADDRESS: begin
          shiftIn <= next_shift;
          cnt     <= next_cnt;
          if (next_cnt == addrCycles(mode)) begin
            // full address kept, buffer uses low byte
            addrReg <= next_shift;
            cnt     <= 6'h00;
            state   <= DEV_DUMMY;
          end
        end
        DEV_DUMMY: begin
          cnt <= next_cnt;
          if (next_cnt == (isBuffer ? BUFFER_DUMMY_CYC : WRAP_DUMMY_CYC)) begin
            state <= DEV_DATA;
          end
        end
        DEV_DATA: begin
          state <= DEV_DATA;
        end
        DEV_IGNORE: begin
          state <= DEV_IGNORE;
        end
        default: begin
          state <= DEV_IGNORE;
        end
      endcase
    end
  end

  // Byte at sequence position seq of the burst
  function automatic logic [7:0] sourceByte(input logic [31:0] seq);
    logic [ARRAY_ADDR_BITS-1:0] lineMask;
    logic [ARRAY_ADDR_BITS-1:0] base;
    logic [ARRAY_ADDR_BITS-1:0] a;
    logic [7:0]                 data;
    lineMask = ARRAY_ADDR_BITS'(lineLength(wCfg)) - 24'h000001;
    base     = addrReg[ARRAY_ADDR_BITS-1:0] & ~lineMask;
    // after the first line, sequential from the next line
    if (wCfg[WRAP_MODE_BIT] && seq >= 32'(lineLength(wCfg))) begin
      a = base + seq[ARRAY_ADDR_BITS-1:0];
    end else begin
      a = base | ((addrReg[ARRAY_ADDR_BITS-1:0] + seq[ARRAY_ADDR_BITS-1:0]) & lineMask);
    end
    data = patternByte(a);
    // only the bank under program reads undefined
    if (wBusy && a[BANK_LSB +: BANK_BITS] == bBank) begin
      data = UNDEFINED_BYTE;
    end
    if (isBuffer) begin
      data = bufMem[8'(addrReg[7:0] + seq[7:0])];
    end
    return data;
  endfunction

  function automatic logic [7:0] unitAt(input logic [31:0] beat);
    logic [2:0] part;
    part = beat[2:0] & 3'((4'h1 << unitShift(mode)) - 4'h1);
    return unitOut(sourceByte(beat >> unitShift(mode)), part, mode);
  endfunction

  // falls: every unit in single rate, odd units in double rate
  always_ff @(negedge link.sck or posedge linkRst) begin
    if (linkRst) begin
      negCnt  <= 32'h00000000;
      negData <= 8'h00;
    end else if (state == DEV_DATA) begin
      negData <= unitAt(dtr ? ((negCnt << 1) - 32'h00000001) : negCnt);
      negCnt  <= negCnt + 32'h00000001;
    end
  end

  // double rate: even units launched on rising edges
  always_ff @(posedge link.sck or posedge linkRst) begin
    if (linkRst) begin
      posData <= 8'h00;
    end else if (state == DEV_DATA && dtr && negCnt != 32'h00000000) begin
      posData <= unitAt((negCnt - 32'h00000001) << 1);
    end
  end

  // lanes driven only in data phase with select low
  assign link.devIoOut = (dtr && link.sck) ? posData : negData;
  assign link.devIoOe  = (!link.csN && state == DEV_DATA) ? dataLanes(mode) : 8'h00;

endmodule
`default_nettype wire

// ### core/bwbr_host_end.sv
// Host end: makes sck by dividing clk, sends opcode, address and dummy cycles,
// collects returned bytes. Data lanes are resynchronised into clk.
`timescale 1ns/1ps
`default_nettype none
module bwbr_host_end
  import bwbr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        useBufferRead,
  input  wire logic [31:0] startAddr,
  input  wire logic [15:0] byteCount,
  input  wire logic [1:0]  lineMode,
  input  wire logic        dtrMode,
  input  wire logic [2:0]  wrapConfig,
  input  wire logic        holdAtLine,
  output logic             busy,
  output logic [7:0]       rdData,
  output logic             rdValid,
  output logic             done,
  bwbr_link_if.host        link
);

  typedef enum logic [2:0] {
    H_IDLE,
    H_SEND,
    H_DUMMY,
    H_DATA,
    H_HALT,
    H_CLOSE
  } bwbr_host_state_type;

  bwbr_host_state_type state;
  logic [3:0]          div;
  logic                tick;
  logic                rising;
  logic                falling;
  logic [39:0]         shiftOut;
  logic [5:0]          cnt;
  logic                bufRead;
  logic                primed;
  logic [7:0]          accum;
  logic [7:0]          next_accum;
  logic [2:0]          units;
  logic [15:0]         bytesGot;
  logic [7:0]          ioS1;
  logic [7:0]          ioS2;
  logic [7:0]          ioS3;
  logic [7:0]          ioHeld;
  logic [7:0]          ioAgree;
  logic                sample;
  logic                byteDone;

  assign ioAgree = ~(ioS2 ^ ioS3);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ioS1   <= 8'hff;
      ioS2   <= 8'hff;
      ioS3   <= 8'hff;
      ioHeld <= 8'hff;
    end else begin
      ioS1   <= link.ioLevel;
      ioS2   <= ioS1;
      ioS3   <= ioS2;
      ioHeld <= (ioS3 & ioAgree) | (ioHeld & ~ioAgree);
    end
  end

  assign tick     = (state == H_SEND || state == H_DUMMY || state == H_DATA)
                    && div == HOST_HALF_DIV - 4'h1;
  assign rising   = tick && !link.sck;
  assign falling  = tick && link.sck;
  // Double rate skips the first rise: the first unit is launched on it
  assign sample   = state == H_DATA && ((rising && (!dtrMode || primed))
                    || (falling && dtrMode && primed));
  assign next_accum = 8'((accum << bitsPerCycle(lineMode)) | dataUnitIn(ioHeld, lineMode));
  assign byteDone = sample && units == 3'((4'h1 << unitShift(lineMode)) - 4'h1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div      <= 4'h0;
      link.sck <= 1'b0;
    end else if (state == H_IDLE || state == H_HALT || state == H_CLOSE) begin
      div <= 4'h0;
      // Clock back low before select rises
      if (link.csN || state == H_CLOSE) begin
        link.sck <= 1'b0;
      end
    end else if (tick) begin
      div      <= 4'h0;
      link.sck <= !link.sck;
    end else begin
      div <= div + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= H_IDLE;
      link.csN <= 1'b1;
      shiftOut <= 40'h0000000000;
      cnt      <= 6'h00;
      bufRead  <= 1'b0;
      primed   <= 1'b0;
      accum    <= 8'h00;
      units    <= 3'h0;
      bytesGot <= 16'h0000;
      rdData   <= 8'h00;
      rdValid  <= 1'b0;
      done     <= 1'b0;
    end else begin
      rdValid <= 1'b0;
      done    <= 1'b0;
      case (state)
        H_IDLE: begin
          if (start && byteCount != 16'h0000) begin
            link.csN <= 1'b0;
            bufRead  <= useBufferRead;
            shiftOut <= {useBufferRead ? OP_BUFFER_READ : OP_WRAP_READ, startAddr};
            cnt      <= 6'h00;
            primed   <= 1'b0;
            units    <= 3'h0;
            bytesGot <= 16'h0000;
            state    <= H_SEND;
          end
        end
        H_SEND: begin
          if (falling) begin
            shiftOut <= shiftOut << bitsPerCycle(lineMode);
            // Lanes held until the fall after the last address edge
            if (cnt == opcodeCycles(lineMode) + addrCycles(lineMode)) begin
              cnt   <= 6'h00;
              state <= H_DUMMY;
            end
          end
          if (rising) begin
            cnt <= cnt + 6'h01;
          end
        end
        H_DUMMY: begin
          if (rising) begin
            cnt <= cnt + 6'h01;
            // one dummy byte for buffer read
            if (cnt + 6'h01 == (bufRead ? BUFFER_DUMMY_CYC : WRAP_DUMMY_CYC)) begin
              state <= H_DATA;
            end
          end
        end
        H_DATA: begin
          if (rising) begin
            primed <= 1'b1;
          end
          if (sample) begin
            accum <= next_accum;
            units <= units + 3'h1;
          end
          if (byteDone) begin
            units    <= 3'h0;
            rdData   <= next_accum;
            rdValid  <= 1'b1;
            bytesGot <= bytesGot + 16'h0001;
            if (bytesGot + 16'h0001 == byteCount) begin
              state <= H_CLOSE;
            // stop the clock at a line end, select held low
            end else if (holdAtLine && !bufRead && ((bytesGot + 16'h0001)
                         & (16'(lineLength(wrapConfig)) - 16'h0001)) == 16'h0000) begin
              state <= H_HALT;
            end
          end
        end
        H_HALT: begin
          if (!holdAtLine) begin
            state <= H_DATA;
          end
        end
        H_CLOSE: begin
          // select released only after the last byte
          if (!link.sck) begin
            link.csN <= 1'b1;
            done     <= 1'b1;
            state    <= H_IDLE;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    case (lineMode)
      LINE_SINGLE: link.hostIoOut = {7'h00, shiftOut[39]};
      LINE_QUAD:   link.hostIoOut = {4'h0, shiftOut[39:36]};
      default:     link.hostIoOut = shiftOut[39:32];
    endcase
  end

  // command lanes follow the selected width
  assign link.hostIoOe = (state == H_SEND) ? cmdLanes(lineMode) : 8'h00;
  assign busy          = state != H_IDLE;

endmodule
`default_nettype wire

// ### test/bwbr_link_chk.sv
// Checker on the link between host end and flash end.
// Takes the link signals plus clk and rst of the host domain as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module bwbr_link_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       csN,
  input wire logic       sck,
  input wire logic [7:0] hostIoOut,
  input wire logic [7:0] hostIoOe,
  input wire logic [7:0] devIoOut,
  input wire logic [7:0] devIoOe,
  input wire logic [7:0] ioLevel
);
  logic       prevSck;
  logic [6:0] riseCnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) prevSck <= 1'b0;
    else prevSck <= sck;
  end

  // Rising sck edges within one frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) riseCnt <= 7'h00;
    else if (csN) riseCnt <= 7'h00;
    else if (sck && !prevSck && riseCnt != 7'h7f) riseCnt <= riseCnt + 7'h01;
  end

  release_lanes_a: assert property (csN |-> devIoOe == 8'h00)
    else $error("flash drives lanes while deselected");
  lane_conflict_a: assert property ((hostIoOe & devIoOe) == 8'h00)
    else $error("both ends drive one lane");
  sck_in_frame_a: assert property ($changed(sck) |-> !csN)
    else $error("sck moves outside a frame");
  frame_start_a: assert property ($fell(csN) |-> !sck [*4])
    else $error("frame does not open with sck low");
  opcode_drive_a: assert property (!csN && riseCnt == 7'h00 |-> hostIoOe[0] && devIoOe == 8'h00)
    else $error("opcode lane not driven by host");
  lane_set_a: assert property (devIoOe inside {8'h00, 8'h02, 8'h0f, 8'hff})
    else $error("flash drives an odd lane set");
  data_stands_a: assert property (!csN && !$past(csN) && $changed(devIoOut) |-> $changed(sck))
    else $error("flash data moved without an sck edge");
  dummy_count_a: assert property ($rose(|devIoOe) |-> riseCnt inside {7'h12, 7'h17, 7'h2f})
    else $error("data starts after a wrong cycle count");

  buf_frame_c: cover property ($rose(|devIoOe) && riseCnt == 7'h2f);
  quad_frame_c: cover property ($rose(|devIoOe) && riseCnt == 7'h17);
  octal_frame_c: cover property ($rose(|devIoOe) && riseCnt == 7'h12);
  halt_c: cover property ((!csN && devIoOe != 8'h00 && $stable(sck)) [*8]);
endmodule
`default_nettype wire

// ### test/burst_wrap_and_buffer_read_tb.sv
// Bench: host end and flash end across the link, scoreboard on returned bytes.
// Assumes package, link interface and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module burst_wrap_and_buffer_read_tb
  import bwbr_pkg::*;
;
  logic        clk, busy, rdValid, done;
  logic        rst = 1'b1, start = 1'b0, useBufferRead = 1'b0, dtrMode = 1'b0;
  logic        holdAtLine = 1'b0, writeBusy = 1'b1, bufWrEn = 1'b0, discard = 1'b0;
  logic [1:0]  lineMode = LINE_SINGLE;
  logic [2:0]  wrapConfig = 3'h0, busyBank = 3'h7;
  logic [7:0]  bufWrIndex = 8'h00, bufWrData = 8'h00, rdData;
  logic [31:0] startAddr = 32'h0, a;
  logic [15:0] byteCount = 16'h0;
  logic [7:0]  bufMem [256];
  logic [7:0]  expQ [$];
  int          err_total = 0, total_checks = 0, cycles = 0;
  integer      seed = 32'hef3d3207;

  bwbr_link_if u_bwbr_link_if ();
  bwbr_host_end u_bwbr_host_end (.clk(clk), .rst(rst), .start(start),
    .useBufferRead(useBufferRead), .startAddr(startAddr), .byteCount(byteCount),
    .lineMode(lineMode), .dtrMode(dtrMode), .wrapConfig(wrapConfig),
    .holdAtLine(holdAtLine), .busy(busy), .rdData(rdData), .rdValid(rdValid),
    .done(done), .link(u_bwbr_link_if));
  bwbr_flash_end u_bwbr_flash_end (.clk(clk), .rst(rst), .wrapConfig(wrapConfig),
    .lineMode(lineMode), .dtrMode(dtrMode), .writeBusy(writeBusy), .busyBank(busyBank),
    .bufWrEn(bufWrEn), .bufWrIndex(bufWrIndex), .bufWrData(bufWrData),
    .link(u_bwbr_link_if));
  bwbr_link_chk u_bwbr_link_chk (.clk(clk), .rst(rst), .csN(u_bwbr_link_if.csN),
    .sck(u_bwbr_link_if.sck), .hostIoOut(u_bwbr_link_if.hostIoOut),
    .hostIoOe(u_bwbr_link_if.hostIoOe), .devIoOut(u_bwbr_link_if.devIoOut),
    .devIoOe(u_bwbr_link_if.devIoOe), .ioLevel(u_bwbr_link_if.ioLevel));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Array byte at burst position i: line loop, then next lines
  function automatic logic [7:0] arrByte(input logic [31:0] s, input int i,
                                         input logic [2:0] cfg);
    logic [31:0] len, b;
    len = 32'h8 << cfg[1:0];
    b = s & ~(len - 32'h1);
    if (!cfg[2] || i < len) b = b + ((s - b + i) % len);
    else b = b + i;
    return b[7:0] ^ b[15:8] ^ b[23:16];
  endfunction

  task automatic launch(input logic ub, input logic [31:0] s, input logic [15:0] n);
    useBufferRead <= ub;
    startAddr <= s;
    byteCount <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask

  task automatic frame(input logic ub, input logic [31:0] s, input logic [15:0] n);
    launch(ub, s, n);
    @(posedge clk iff done);
  endtask

  // New settings reach the flash end through one throw-away frame
  task automatic setMode(input logic [1:0] m, input logic d, input logic [2:0] c);
    if ({m, d, c} !== {lineMode, dtrMode, wrapConfig}) begin
      lineMode <= m;
      dtrMode <= d;
      wrapConfig <= c;
      discard <= 1'b1;
      frame(m == LINE_SINGLE, 32'h0, 16'h0002);
      discard <= 1'b0;
    end
  endtask

  task automatic holdRead(input logic [31:0] s, input int n);
    int h, still, len;
    logic lastSck, lastUnit;
    logic [7:0] e;
    h = 0;
    still = 0;
    lastSck = 1'b0;
    len = 8 << wrapConfig[1:0];
    for (int i = 0; i < n; i++) expQ.push_back(arrByte(s, i, wrapConfig));
    holdAtLine <= 1'b1;
    launch(1'b0, s, 16'(n));
    while (!done) begin
      @(posedge clk);
      still = (u_bwbr_link_if.sck == lastSck) ? still + 1 : 0;
      lastSck = u_bwbr_link_if.sck;
      if (still == 40) begin
        lastUnit = lastSck ^ dtrMode;
        e = arrByte(s, (h + 1) * len - int'(lastUnit), wrapConfig);
        if (lineMode == LINE_QUAD) e = {4'h0, lastUnit ? e[3:0] : e[7:4]};
        check(lineMode == LINE_QUAD ? {4'h0, u_bwbr_link_if.ioLevel[3:0]}
              : u_bwbr_link_if.ioLevel, e);
        h++;
        still = 0;
        holdAtLine <= 1'b0;
        repeat (4) @(posedge clk);
        holdAtLine <= 1'b1;
      end
    end
    holdAtLine <= 1'b0;
    check(8'(h), 8'h02);
  endtask

  always @(posedge clk) begin
    if (rdValid && !discard) begin
      if (expQ.size() == 0) begin
        err_total++;
        $display("[FAIL] %0t ns: byte with nothing expected", $time);
      end else check(rdData, expQ.pop_front());
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      err_total++;
      $display("[FAIL] %0t ns: run too long", $time);
      end_sim();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 256; i++) begin
      bufMem[i] = 8'($random(seed));
      bufWrEn <= 1'b1;
      bufWrIndex <= 8'(i);
      bufWrData <= bufMem[i];
      @(posedge clk);
    end
    bufWrEn <= 1'b0;
    for (int i = 0; i < 8; i++) expQ.push_back(bufMem[8'(8'hfc + i)]);
    frame(1'b1, {24'($random(seed)), 8'hfc}, 16'h0008);
    $display("Test buffer read done");
    for (int m = 0; m < 2; m++) begin
      setMode(m ? LINE_QUAD : LINE_SINGLE, 1'b0, 3'h0);
      expQ.push_back(8'hff);
      expQ.push_back(8'hff);
      frame(m == 1, 32'h100, 16'h0002);
      $display("Test refusal %0d done", m);
    end
    // addresses stay clear of busy bank 7
    for (int k = 0; k < 8; k++) begin
      setMode(k[0] ? LINE_OCTAL : LINE_QUAD, k[1], 3'(k));
      a = $random(seed) & 32'h007ffffe;
      for (int i = 0; i < 2 * (8 << k[1:0]) + 4; i++) expQ.push_back(arrByte(a, i, 3'(k)));
      frame(1'b0, a, 16'(2 * (8 << k[1:0]) + 4));
      $display("Test wrap %0d done", k);
    end
    setMode(LINE_QUAD, 1'b0, 3'h4);
    holdRead(32'h1e34, 24);
    setMode(LINE_OCTAL, 1'b1, 3'h4);
    holdRead(32'h1e34, 24);
    $display("Test halt done");
    check(8'(expQ.size()), 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
